// >>> branch_jump_trap_unit.sv
// decode and resolution of jumps, branches, links and software traps
`timescale 1ns/100ps
`default_nettype none
module branch_jump_trap_unit
    import xfer_pkg::*;
(
    // core clock and synchronous reset, active low
    input wire logic mclk,
    input wire logic nrst,
    // decode stage: at most one instruction word per clock
    input wire logic instr_valid,        // decode stage holds an instruction
    input wire logic [31:0] instr,       // instruction word
    input wire logic [31:0] instr_pc,    // its address
    input wire logic [31:0] src_a_val,   // source_reg_a contents
    input wire logic [31:0] src_b_val,   // source_reg_b contents
    // towards instruction fetch; all answers land one clock after the word
    output logic redirect,               // take target after delay slot
    output logic [31:0] target,          // next fetch address
    output logic slot_pending,           // next instruction is a delay slot
    // towards the register file write port
    output logic link_we,                // register file write
    output logic [4:0] link_idx,         // register index written
    output logic [31:0] link_val,        // return address written
    // towards the exception logic
    output logic trap_req,               // trap request to exception logic
    output logic [1:0] trap_cause,       // trap kind
    output logic [31:0] trap_pc          // address of trapping instruction
);
    // ============================================================
    // state
    // every output is a field of this one register, so no decode
    // path reaches a pin of the unit and timing stays local
    xfer_state_t st;       // registered state
    // combinational copy that the decode fills in
    xfer_state_t next_st;  // next value

    // ============================================================
    // field extraction
    // decoded fields of the word on the instr port
    // names follow the job each field does in this unit
    logic [5:0] opc;
    logic [5:0] fn;
    logic [4:0] sel_b;
    logic [4:0] dest;
    // address arithmetic, all modulo two to the 32
    logic [31:0] slot_pc;    // delay-slot address
    logic [31:0] abs_tgt;    // absolute target
    logic [31:0] br_tgt;     // relative target
    logic [31:0] ofs_ext;    // offset shifted and sign-extended
    // sign view of source_reg_a for the compares against zero
    logic a_neg;             // sign bit of source_reg_a
    logic a_zero;            // zero detect of source_reg_a

    // fixed field positions; the same slices feed every decode branch
    assign opc = instr[OP_HI:OP_LO];
    assign fn = instr[FUNC_HI:FUNC_LO];
    assign sel_b = instr[SRCB_HI:SRCB_LO];
    assign dest = instr[DEST_HI:DEST_LO];
    // address of the delay slot; relative targets hang off it
    assign slot_pc = instr_pc + SLOT_STEP;
    // top four pc bits, field times four
    // an absolute jump cannot leave the region picked by those
    // top bits; crossing it needs a register jump
    assign abs_tgt = {instr_pc[31:32-PC_TOP_W], instr[TGT_W-1:0], 2'b00};
    // sign-extend then scale; the pair equals shift then extend
    // copies of the offset sign fill the top of the word
    assign ofs_ext = {{(32-OFS_W-2){instr[OFS_W-1]}}, instr[OFS_W-1:0], 2'b00};
    // one adder serves every relative branch, taken or not
    assign br_tgt = slot_pc + ofs_ext;
    // signed view via msb plus zero detect, no full comparator
    assign a_neg = src_a_val[31];
    assign a_zero = (src_a_val == 32'h0000_0000);

    // ============================================================
    // decode and next-state
    // one clock from word to answer; nothing here waits on history
    always_comb begin
        // hold everything by default, then drop the one-cycle pulses
        next_st = st;
        next_st.redirect = 1'b0;
        next_st.link_we = 1'b0;
        // index and value only mean something while link_we is high
        next_st.link_idx = st.link_idx;
        next_st.trap_req = 1'b0;
        next_st.trap_cause = CAUSE_NONE;
        // a valid instruction after a transfer is its slot; clear the mark
        // a transfer sitting in the slot sets it again below
        if (instr_valid) begin
            next_st.slot_pending = 1'b0;
        end

        // words with instr_valid low are bubbles; they only let the pulses drop
        if (instr_valid) begin
            // unknown opcodes fall to the default and leave pulses low
            case (opc)
                // jump forms always redirect, slot still runs
                // plain goto writes nothing back
                OPC_GOTO: begin
                    next_st.redirect = 1'b1;
                    next_st.target = abs_tgt;
                    next_st.slot_pending = 1'b1;
                end
                // absolute call: goto target plus a link to the word
                // after the delay slot
                OPC_CALL: begin
                    next_st.redirect = 1'b1;
                    next_st.target = abs_tgt;
                    next_st.slot_pending = 1'b1;
                    next_st.link_we = 1'b1;
                    next_st.link_idx = LINK_REG_IDX;
                    next_st.link_val = instr_pc + LINK_STEP;
                end
                // two-register compares
                // target is loaded even when not taken; fetch looks at it
                // only while redirect is high
                OPC_EQ, OPC_NE: begin
                    next_st.slot_pending = 1'b1;
                    next_st.target = br_tgt;
                    next_st.redirect = (opc == OPC_EQ) ? (src_a_val == src_b_val)
                                                       : (src_a_val != src_b_val);
                end
                // sign tests against zero
                // zero counts as nonpositive, hence the zero detect
                OPC_POS, OPC_NONPOS: begin
                    next_st.slot_pending = 1'b1;
                    next_st.target = br_tgt;
                    next_st.redirect = (opc == OPC_POS) ? (!a_neg && !a_zero)
                                                        : (a_neg || a_zero);
                end
                // sign group: the selector sits in the source_reg_b field,
                // bit 4 asks for a link and bit 0 for the nonnegative sense
                OPC_SIGNBR: begin
                    // unknown selectors do nothing
                    // so a bad selector acts as a plain slot instruction
                    if (sel_b == SB_NEG || sel_b == SB_NONNEG ||
                        sel_b == SB_LINK_NEG || sel_b == SB_LINK_NONNEG) begin
                        next_st.slot_pending = 1'b1;
                        next_st.target = br_tgt;
                        // low bit picks nonnegative
                        next_st.redirect = sel_b[0] ? !a_neg : a_neg;
                        // link written whether or not taken
                        if (sel_b[4]) begin
                            next_st.link_we = 1'b1;
                            next_st.link_idx = LINK_REG_IDX;
                            next_st.link_val = instr_pc + LINK_STEP;
                        end
                    end
                end
                // traps live only in the register format
                // register jumps pass the whole value on; a misaligned
                // address is left for the fetch stage to refuse
                OPC_REGTYPE: begin
                    case (fn)
                        FN_REG_GOTO, FN_REG_CALL: begin
                            next_st.redirect = 1'b1;
                            next_st.target = src_a_val;
                            next_st.slot_pending = 1'b1;
                            if (fn == FN_REG_CALL) begin
                                next_st.link_we = 1'b1;
                                next_st.link_idx = dest;
                                next_st.link_val = instr_pc + LINK_STEP;
                            end
                        end
                        // pulse and cause leave together; trap_pc holds the
                        // trapping address until the next trap
                        FN_SYS_TRAP: begin
                            next_st.trap_req = 1'b1;
                            next_st.trap_cause = CAUSE_SYSTEM_TRAP;
                            next_st.trap_pc = instr_pc;
                        end
                        // breakpoint differs only in its cause code
                        FN_DBG_TRAP: begin
                            next_st.trap_req = 1'b1;
                            next_st.trap_cause = CAUSE_BREAK;
                            next_st.trap_pc = instr_pc;
                        end
                        default: begin
                            // other register ops belong elsewhere
                            // shifts and arithmetic of the register format
                        end
                    endcase
                end
                default: begin
                    // not a control transfer
                    // arithmetic, loads and stores pass through untouched
                end
            endcase
        end
    end

    // ============================================================
    // state register with synchronous reset
    // reset is sampled like any input, so it is a clear mux in front
    // of plain flops; it must be held for one full edge at least
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            // every field known, every pulse low
            st <= '{redirect: 1'b0,
                    target: RESET_ADDR,
                    link_we: 1'b0,
                    link_idx: RESET_IDX,
                    link_val: RESET_ADDR,
                    trap_req: 1'b0,
                    trap_cause: CAUSE_NONE,
                    trap_pc: RESET_ADDR,
                    slot_pending: 1'b0};
        end else begin
            st <= next_st;
        end
    end

    // ============================================================
    // outputs straight from the state flops
    // fetch side
    assign redirect = st.redirect;
    assign target = st.target;
    assign slot_pending = st.slot_pending;
    // register file side
    assign link_we = st.link_we;
    assign link_idx = st.link_idx;
    assign link_val = st.link_val;
    // exception side
    assign trap_req = st.trap_req;
    assign trap_cause = st.trap_cause;
    assign trap_pc = st.trap_pc;
endmodule : branch_jump_trap_unit
`default_nettype wire

// >>> xfer_pkg.sv
// constants and types for the branch, jump and trap unit
// ============================================================
// What this block does
// - delay slot always runs after any transfer
// - absolute target: pc top four, field shifted
// - absolute_call links into link_register
// - register forms jump to source_reg_a value
// - branch target: slot address plus shifted offset
// - equal and unequal compare both sources
// - positive and nonpositive sign tests
// - nonnegative and negative sign tests
// - linking sign branches write link_register
// - system_trap raises system-call trap immediately
// - debug_trap raises breakpoint trap immediately
// - traps decoded only in register format
package xfer_pkg;
    // ============================================================
    // instruction fields
    localparam int OP_HI = 31;
    localparam int OP_LO = 26;
    localparam int SRCA_HI = 25;
    localparam int SRCA_LO = 21;
    localparam int SRCB_HI = 20;
    localparam int SRCB_LO = 16;
    localparam int DEST_HI = 15;
    localparam int DEST_LO = 11;
    localparam int FUNC_HI = 5;
    localparam int FUNC_LO = 0;
    localparam int TGT_W = 26;
    localparam int OFS_W = 16;
    localparam int PC_TOP_W = 4;
    // ============================================================
    // primary opcodes
    localparam logic [5:0] OPC_REGTYPE = 6'h00;
    localparam logic [5:0] OPC_SIGNBR = 6'h01;
    localparam logic [5:0] OPC_GOTO = 6'h02;
    localparam logic [5:0] OPC_CALL = 6'h03;
    localparam logic [5:0] OPC_EQ = 6'h04;
    localparam logic [5:0] OPC_NE = 6'h05;
    localparam logic [5:0] OPC_NONPOS = 6'h06;
    localparam logic [5:0] OPC_POS = 6'h07;
    // register-format function codes
    localparam logic [5:0] FN_REG_GOTO = 6'h08;
    localparam logic [5:0] FN_REG_CALL = 6'h09;
    localparam logic [5:0] FN_SYS_TRAP = 6'h0C;
    localparam logic [5:0] FN_DBG_TRAP = 6'h0D;
    // sign-branch selector in source_reg_b field
    localparam logic [4:0] SB_NEG = 5'h00;
    localparam logic [4:0] SB_NONNEG = 5'h01;
    localparam logic [4:0] SB_LINK_NEG = 5'h10;
    localparam logic [4:0] SB_LINK_NONNEG = 5'h11;
    // ============================================================
    // link register index and address step
    localparam logic [4:0] LINK_REG_IDX = 5'h1F;
    localparam logic [31:0] SLOT_STEP = 32'h0000_0004;
    localparam logic [31:0] LINK_STEP = 32'h0000_0008;
    // trap cause codes
    localparam logic [1:0] CAUSE_NONE = 2'h0;
    localparam logic [1:0] CAUSE_SYSTEM_TRAP = 2'h1;
    localparam logic [1:0] CAUSE_BREAK = 2'h2;
    // reset values
    localparam logic [31:0] RESET_ADDR = 32'h0000_0000;
    localparam logic [4:0] RESET_IDX = 5'h00;
    // ============================================================
    // all registered state of the unit
    typedef struct packed {
        logic redirect;         // target valid after slot
        logic [31:0] target;    // next fetch after slot
        logic link_we;          // register-file write strobe
        logic [4:0] link_idx;   // register written
        logic [31:0] link_val;  // return address
        logic trap_req;         // trap to exception logic
        logic [1:0] trap_cause; // which trap
        logic [31:0] trap_pc;   // address of trapping instruction
        logic slot_pending;     // next instruction is a delay slot
    } xfer_state_t;
endpackage : xfer_pkg

// >>> bjt_checker_sva.sv
// concurrent checks on the ports of the branch, jump and trap unit
`timescale 1ns/100ps
`default_nettype none
module bjt_checker
    import xfer_pkg::*;
(
    input wire logic mclk,
    input wire logic nrst,
    input wire logic instr_valid,
    input wire logic redirect,
    input wire logic slot_pending,
    input wire logic link_we,
    input wire logic trap_req,
    input wire logic [31:0] instr,
    input wire logic [31:0] instr_pc,
    input wire logic [31:0] src_a_val,
    input wire logic [31:0] src_b_val,
    input wire logic [31:0] target,
    input wire logic [31:0] link_val,
    input wire logic [31:0] trap_pc,
    input wire logic [4:0] link_idx,
    input wire logic [1:0] trap_cause
);
    // ============================================================
    // decoded fields and expected addresses, so $past sees plain signals
    logic [5:0] op, fn;
    logic [31:0] abs_tgt, br_tgt, ret;
    logic pos, same, rty;
    assign op = instr[OP_HI:OP_LO];
    assign fn = instr[FUNC_HI:FUNC_LO];
    assign rty = instr_valid && op == OPC_REGTYPE;
    assign abs_tgt = {instr_pc[31:28], instr[25:0], 2'h0};
    assign br_tgt = instr_pc + SLOT_STEP + {{14{instr[15]}}, instr[15:0], 2'h0};
    assign ret = instr_pc + LINK_STEP;
    assign pos = !src_a_val[31] && src_a_val != 32'h0;
    assign same = src_a_val == src_b_val;
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!nrst);
    chk_abs_target: assert property (instr_valid && op == OPC_GOTO |=>
        redirect && slot_pending && target == $past(abs_tgt)) else $error("bad goto target");
    chk_call_link: assert property (instr_valid && op == OPC_CALL |=>
        link_we && link_idx == LINK_REG_IDX && link_val == $past(ret)) else $error("bad link");
    chk_eq_branch: assert property (instr_valid && op == OPC_EQ |=>
        redirect == $past(same) && target == $past(br_tgt)) else $error("bad equal branch");
    chk_pos_test: assert property (instr_valid && op == OPC_POS |=>
        redirect == $past(pos)) else $error("bad positive test");
    chk_reg_goto: assert property (rty && fn == FN_REG_GOTO |=>
        redirect && target == $past(src_a_val)) else $error("bad register target");
    chk_sys_trap: assert property (rty && fn == FN_SYS_TRAP |=> trap_req &&
        trap_cause == CAUSE_SYSTEM_TRAP && trap_pc == $past(instr_pc)) else $error("bad system_trap");
    chk_break_trap: assert property (rty && fn == FN_DBG_TRAP |=>
        trap_req && trap_cause == CAUSE_BREAK) else $error("bad breakpoint");
    chk_trap_format: assert property (instr_valid && op != OPC_REGTYPE |=>
        !trap_req) else $error("trap outside register format");
    cov_call: cover property (instr_valid && op == OPC_CALL);
    cov_trap: cover property (trap_req);
    cov_link_untaken: cover property (link_we && !redirect);
    cov_reg_goto: cover property (rty && fn == FN_REG_GOTO);
endmodule : bjt_checker
bind branch_jump_trap_unit bjt_checker bjt_checker_i (.mclk, .nrst, .instr_valid, .redirect,
    .slot_pending, .link_we, .trap_req, .instr, .instr_pc, .src_a_val, .src_b_val, .target,
    .link_val, .trap_pc, .link_idx, .trap_cause);
`default_nettype wire

// >>> core_side_model.sv
// register file side that takes the unit's link writes
`timescale 1ns/100ps
`default_nettype none
module core_side_model (
    input wire logic mclk,
    input wire logic link_we,
    input wire logic [4:0] link_idx,
    input wire logic [31:0] link_val
);
    // ============================================================
    // register zero is never written, so a stray link there is dropped
    logic [31:0] regs [32];
    always_ff @(posedge mclk) begin
        if (link_we && link_idx != 5'h00) begin
            regs[link_idx] <= link_val;
        end
    end
endmodule : core_side_model
`default_nettype wire

// >>> branch_jump_trap_unit_tb.sv
// self-checking bench for the branch, jump and trap unit
`timescale 1ns/100ps
`default_nettype none
module branch_jump_trap_unit_tb;
    import xfer_pkg::*;
    // ============================================================
    // stimulus, outputs and score; source_reg_b stays at one
    logic mclk = 1'b0, nrst = 1'b0, instr_valid = 1'b0;
    logic [31:0] instr = 32'h0, instr_pc = 32'h0, src_a_val = 32'h0, src_b_val = 32'h1;
    logic redirect, slot_pending, link_we, trap_req;
    logic [31:0] target, link_val, trap_pc;
    logic [4:0] link_idx;
    logic [1:0] trap_cause;
    int num_errors = 0, samples_checked = 0;
    always #5 mclk = ~mclk;
    branch_jump_trap_unit branch_jump_trap_unit_i (.mclk, .nrst, .instr_valid, .instr, .instr_pc,
        .src_a_val, .src_b_val, .redirect, .target, .slot_pending, .link_we, .link_idx,
        .link_val, .trap_req, .trap_cause, .trap_pc);
    core_side_model core_side_model_i (.mclk, .link_we, .link_idx, .link_val);
    task automatic chk(input string what, input logic [31:0] exp, got);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // one instruction for one edge; answer is read once that edge has landed
    task automatic issue(input logic [31:0] w, pc, a);
        @(posedge mclk);
        instr_valid <= 1'b1;
        instr <= w;
        instr_pc <= pc;
        src_a_val <= a;
        @(posedge mclk);
        instr_valid <= 1'b0;
        #1;
    endtask : issue
    task automatic t_jumps;
        issue({OPC_GOTO, 26'h3ABCDEF}, 32'hA000_0010, 32'h0);
        chk("target", {4'hA, 26'h3ABCDEF, 2'h0}, target);
        chk("redirect", 32'h1, redirect);
        chk("link_we", 32'h0, link_we);
        chk("slot", 32'h1, slot_pending);
        issue(32'h2000_0000, 32'hA000_0014, 32'h0);
        chk("slot", 32'h0, slot_pending);
        issue({OPC_CALL, 26'h0000040}, 32'h1234_5678, 32'h0);
        chk("target", {4'h1, 26'h40, 2'h0}, target);
        chk("link_val", 32'h1234_5680, link_val);
        issue({OPC_REGTYPE, 10'h0, 5'h7, 5'h0, FN_REG_CALL}, 32'h200, 32'h0040_1000);
        chk("target", 32'h0040_1000, target);
        chk("link_idx", 32'h7, link_idx);
        chk("link_val", 32'h0000_0208, link_val);
        issue({OPC_REGTYPE, 10'h0, 5'h5, 5'h0, FN_REG_GOTO}, 32'h100, 32'h0000_2000);
        chk("target", 32'h0000_2000, target);
        chk("redirect", 32'h1, redirect);
        chk("link_we", 32'h0, link_we);
        chk("reg 7", 32'h0000_0208, core_side_model_i.regs[7]);
        chk("reg 31", 32'h1234_5680, core_side_model_i.regs[31]);
    endtask : t_jumps
    // every compare kind against zero, one, minus one and the most negative value
    task automatic t_branch;
        logic [31:0] av [4] = '{32'h0, 32'h1, 32'hFFFF_FFFF, 32'h8000_0000};
        int s;
        logic tk;
        for (int k = 0; k < 8; k++) begin
            for (int i = 0; i < 4; i++) begin
                s = av[i];
                tk = k == 0 ? s == 1 : k == 1 ? s != 1 : k == 2 ? s <= 0 : k == 3 ? s > 0 :
                    k[0] ? s >= 0 : s < 0;
                if (k < 4) issue({6'(k + 4), 10'h0, 16'hFFFE}, 32'h1000, av[i]);
                else issue({OPC_SIGNBR, 5'h0, k[1], 3'h0, k[0], 16'hFFFE}, 32'h1000, av[i]);
                chk("taken", tk, redirect);
                chk("target", 32'h0000_0FFC, target);
                chk("link_we", k >= 6, link_we);
                chk("slot", 32'h1, slot_pending);
                if (k >= 6) begin
                    chk("link_idx", 32'h1F, link_idx);
                    chk("link_val", 32'h0000_1008, link_val);
                end
            end
        end
        // unknown sign selector: no transfer although the value is negative
        issue({OPC_SIGNBR, 5'h0, 5'h02, 16'h0004}, 32'h1000, 32'h8000_0000);
        chk("taken", 32'h0, redirect);
        chk("slot", 32'h0, slot_pending);
    endtask : t_branch
    task automatic t_trap;
        issue({OPC_REGTYPE, 20'h0, FN_SYS_TRAP}, 32'h300, 32'h0);
        chk("cause", CAUSE_SYSTEM_TRAP, trap_cause);
        chk("trap_req", 32'h1, trap_req);
        chk("trap_pc", 32'h300, trap_pc);
        issue({OPC_REGTYPE, 20'h0, FN_DBG_TRAP}, 32'h304, 32'h0);
        chk("cause", CAUSE_BREAK, trap_cause);
        chk("trap_pc", 32'h304, trap_pc);
        issue({6'h08, 20'h0, FN_SYS_TRAP}, 32'h308, 32'h0);
        chk("trap_req", 32'h0, trap_req);
    endtask : t_trap
    // every output at its value after reset
    task automatic t_idle;
        chk("redirect", 32'h0, redirect);
        chk("target", RESET_ADDR, target);
        chk("slot", 32'h0, slot_pending);
        chk("link_we", 32'h0, link_we);
        chk("link_idx", RESET_IDX, link_idx);
        chk("link_val", RESET_ADDR, link_val);
        chk("trap_req", 32'h0, trap_req);
        chk("cause", CAUSE_NONE, trap_cause);
        chk("trap_pc", RESET_ADDR, trap_pc);
    endtask : t_idle
    // reset in mid-run, one idle edge after a call has set the outputs
    task automatic t_reset;
        issue({OPC_CALL, 26'h0000010}, 32'h0000_0400, 32'h0);
        @(posedge mclk);
        nrst <= 1'b0;
        repeat (2) @(posedge mclk);
        nrst <= 1'b1;
        #1;
        t_idle();
    endtask : t_reset
    task automatic final_report;
        if (num_errors == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : final_report
    initial begin
        repeat (10) @(posedge mclk);
        nrst <= 1'b1;
        #1;
        t_idle();
        t_jumps();
        t_branch();
        t_trap();
        t_reset();
        final_report();
    end
endmodule : branch_jump_trap_unit_tb
`default_nettype wire
